// *** rtl/swrst_ctrl.sv ***
// Reset sequencer and strap decoder for the switch.
// Assumes straps and fundamental reset arrive on pins; the halt bit of
// the switch control register arrives as a level from the SMBus logic.
`timescale 1ns/1ns
`include "swrst_regs.svh"
module swrst_ctrl #(
  parameter logic [7:0] PROC_CYCLES = `SWRST_PROC_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Pins
  input wire logic fundamental_reset_n,
  input wire logic reset_halt,
  input wire logic [3:0] switch_mode_sel,
  input wire logic port67_merge_n,
  // Halt bit of switch_control_reg, same clock domain
  input wire logic ctl_reset_halt_bit,
  // Reset and halt status
  output logic core_reset_r,
  output logic smbus_enable_r,
  output logic halted_r,
  output logic halt_bit_set_r,
  // Decoded configuration
  output logic [3:0] mode_r,
  output logic mode_reserved_r,
  output logic eeprom_init_r,
  output logic single_part_r,
  output logic [2:0] upstream_port_r,
  output logic port0_disable_r,
  output logic port2_disable_r,
  output logic port67_merged_r,
  output logic [3:0] port6_width_r,
  output logic port7_enable_r
);
  typedef struct packed {
    swrst_pkg::swrst_state_e state;
    logic [7:0] cnt;
    logic halt_lat;
    logic [3:0] mode;
    logic merge_n;
    logic core_reset;
    logic smbus_en;
    logic halt_bit_set;
  } swrst_ctrl_s;

  swrst_ctrl_s st_r, st_nxt;
  logic perst_n_s, halt_s, merge_n_s;
  logic [3:0] mode_s;
  logic valid;

  // Pins pass two flops before any logic looks at them
  swrst_sync #(.WIDTH(7), .INIT(`SWRST_SYNC_INIT)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_in({port67_merge_n, fundamental_reset_n, reset_halt,
             switch_mode_sel}),
    .sync_out({merge_n_s, perst_n_s, halt_s, mode_s})
  );

  // Reserved codes, including undefined C and D, count as invalid
  function automatic logic mode_valid(input logic [3:0] m);
    unique case (m)
      `SWRST_MODE_NORMAL, `SWRST_MODE_NORMAL_EE,
      `SWRST_MODE_SP_P0, `SWRST_MODE_SP_P2,
      `SWRST_MODE_SP_P0_EE, `SWRST_MODE_SP_P2_EE: mode_valid = 1'b1;
      default: mode_valid = 1'b0;
    endcase
  endfunction

  assign valid = mode_valid(st_r.mode);

  // Sequencer: straps are caught while reset is asserted; afterwards the
  // latched copy is used, so strap wiggles cannot reshape the fabric.
  always_comb begin
    st_nxt = st_r;
    unique case (st_r.state)
      swrst_pkg::SWRST_IN_RESET: begin
        st_nxt.core_reset = 1'b1;
        st_nxt.smbus_en = 1'b0;
        st_nxt.halt_lat = halt_s;
        st_nxt.mode = mode_s;
        st_nxt.merge_n = merge_n_s;
        st_nxt.cnt = `SWRST_CNT_ZERO;
        if (perst_n_s) begin
          st_nxt.state = swrst_pkg::SWRST_PROC;
        end
      end
      swrst_pkg::SWRST_PROC: begin
        st_nxt.cnt = st_r.cnt + `SWRST_CNT_ONE;
        if (st_r.cnt == PROC_CYCLES - `SWRST_CNT_ONE) begin
          st_nxt.smbus_en = 1'b1;
          if (st_r.halt_lat) begin
            st_nxt.state = swrst_pkg::SWRST_HALT;
            st_nxt.halt_bit_set = 1'b1;
          end else begin
            st_nxt.state = swrst_pkg::SWRST_RUN;
            st_nxt.core_reset = 1'b0;
          end
        end
      end
      swrst_pkg::SWRST_HALT: begin
        st_nxt.smbus_en = 1'b1;
        st_nxt.halt_bit_set = 1'b0;
        if (!ctl_reset_halt_bit && !st_r.halt_bit_set) begin
          st_nxt.state = swrst_pkg::SWRST_RUN;
          st_nxt.core_reset = 1'b0;
        end
      end
      swrst_pkg::SWRST_RUN: begin
        st_nxt.core_reset = 1'b0;
        st_nxt.smbus_en = 1'b1;
      end
    endcase
    if (!perst_n_s) begin
      st_nxt.state = swrst_pkg::SWRST_IN_RESET;
      st_nxt.core_reset = 1'b1;
      st_nxt.smbus_en = 1'b0;
      st_nxt.halt_bit_set = 1'b0;
    end
  end

  // Single state register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r <= '{state: swrst_pkg::SWRST_IN_RESET, cnt: `SWRST_CNT_ZERO,
                halt_lat: 1'b0, mode: `SWRST_MODE_NORMAL, merge_n: 1'b0,
                core_reset: 1'b1, smbus_en: 1'b0, halt_bit_set: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Registered outputs: status from the next state, configuration decoded from the latched straps
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      core_reset_r <= 1'b1;
      smbus_enable_r <= 1'b0;
      halted_r <= 1'b0;
      halt_bit_set_r <= 1'b0;
      mode_r <= `SWRST_MODE_NORMAL;
      mode_reserved_r <= 1'b0;
      eeprom_init_r <= 1'b0;
      single_part_r <= 1'b0;
      upstream_port_r <= `SWRST_PORT0;
      port0_disable_r <= 1'b0;
      port2_disable_r <= 1'b0;
      port67_merged_r <= 1'b0;
      port6_width_r <= `SWRST_WIDTH_X4;
      port7_enable_r <= 1'b1;
    end else begin
      core_reset_r <= st_nxt.core_reset;
      smbus_enable_r <= st_nxt.smbus_en;
      halted_r <= (st_nxt.state == swrst_pkg::SWRST_HALT);
      halt_bit_set_r <= st_nxt.halt_bit_set;
      mode_r <= st_r.mode;
      mode_reserved_r <= !valid;
      // Reserved codes fall back to plain normal mode
      // Single-partition codes carry EEPROM in bit 1, normal ones in bit 0
      eeprom_init_r <= valid && (st_r.mode[3] ? st_r.mode[1]
                                              : st_r.mode[0]);
      single_part_r <= valid && st_r.mode[3];
      upstream_port_r <= (valid && st_r.mode[3] && st_r.mode[0]) ?
                         `SWRST_PORT2 : `SWRST_PORT0;
      port0_disable_r <= valid && st_r.mode[3] && st_r.mode[0];
      port2_disable_r <= valid && st_r.mode[3] && !st_r.mode[0];
      port67_merged_r <= !st_r.merge_n;
      port6_width_r <= st_r.merge_n ? `SWRST_WIDTH_X4
                                    : `SWRST_WIDTH_X8;
      port7_enable_r <= st_r.merge_n;
    end
  end

  // Core held in reset while fundamental reset is seen
  reset_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    !perst_n_s |=> ##1 core_reset_r) else $error("core left reset");

  // Halt keeps core in reset while the bit stays set
  halt_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    halted_r && ctl_reset_halt_bit && perst_n_s |=> core_reset_r)
    else $error("halt released early");

  // SMBus usable during halt
  halt_smbus_a: assert property (@(posedge clk_sys) disable iff (reset)
    halted_r |-> smbus_enable_r) else $error("smbus off in halt");

  // Clearing the bit after the set pulse releases the core next cycle
  halt_release_a: assert property (@(posedge clk_sys) disable iff (reset)
    halted_r && !ctl_reset_halt_bit && !halt_bit_set_r && perst_n_s |=>
    !core_reset_r && !halted_r) else $error("halt not released");

  // Merge widths
  merge_width_a: assert property (@(posedge clk_sys) disable iff (reset)
    port67_merged_r |-> port6_width_r == `SWRST_WIDTH_X8 && !port7_enable_r)
    else $error("merged width wrong");

  split_width_a: assert property (@(posedge clk_sys) disable iff (reset)
    !port67_merged_r |-> port6_width_r == `SWRST_WIDTH_X4 && port7_enable_r)
    else $error("split width wrong");

  // Mode decode
  mode_upstream_a: assert property (@(posedge clk_sys) disable iff (reset)
    $past(st_r.mode) == `SWRST_MODE_SP_P2_EE |-> upstream_port_r ==
    `SWRST_PORT2 && eeprom_init_r && port0_disable_r)
    else $error("mode B decode");

  mode_normal_a: assert property (@(posedge clk_sys) disable iff (reset)
    $past(st_r.mode) == `SWRST_MODE_NORMAL_EE |-> eeprom_init_r &&
    !single_part_r) else $error("mode 1 decode");

  mode_single_a: assert property (@(posedge clk_sys) disable iff (reset)
    $past(st_r.mode) == `SWRST_MODE_SP_P0 |-> single_part_r &&
    !eeprom_init_r && port2_disable_r) else $error("mode 8 decode");
endmodule

// *** rtl/swrst_pkg.sv ***
// Types for the switch reset and strap configuration block.
// Assumes the constants header is included where numbers are needed.
package swrst_pkg;
  // Gray codes along reset, procedure, halt, run
  typedef enum logic [1:0] {
    SWRST_IN_RESET = 2'h0,
    SWRST_PROC = 2'h1,
    SWRST_HALT = 2'h3,
    SWRST_RUN = 2'h2
  } swrst_state_e;
endpackage

// *** rtl/swrst_regs.svh ***
// Constants for the switch reset and strap configuration block.
// Assumes inclusion by bare name from rtl files; definitions only.
// Operation
// - Merge low joins ports 6,7 as x8
// - Merge high keeps ports 6,7 as x4
// - Fundamental reset clears all internal logic; here only the sequencer restarts and the straps are relatched
// - Halt strap holds device after reset procedure
// - Clearing halt bit releases held reset state
// - Modes 0,1: normal, EEPROM optional
// - Modes 8,9: single partition, upstream 0/2
// - Modes A,B: single partition with EEPROM
`ifndef SWRST_REGS_SVH
`define SWRST_REGS_SVH
`define SWRST_MODE_NORMAL 4'h0
`define SWRST_MODE_NORMAL_EE 4'h1
`define SWRST_MODE_SP_P0 4'h8
`define SWRST_MODE_SP_P2 4'h9
`define SWRST_MODE_SP_P0_EE 4'hA
`define SWRST_MODE_SP_P2_EE 4'hB
`define SWRST_PROC_CYCLES 8'h10
`define SWRST_SYNC_INIT 7'h10
`define SWRST_CNT_ZERO 8'h00
`define SWRST_CNT_ONE 8'h01
`define SWRST_PORT0 3'h0
`define SWRST_PORT2 3'h2
`define SWRST_WIDTH_X4 4'h4
`define SWRST_WIDTH_X8 4'h8
`endif

// *** rtl/swrst_sync.sv ***
// Two-flop synchroniser for a bus of pin inputs.
// Assumes pins are asynchronous to clk_sys; reset is synchronous.
`timescale 1ns/1ns
module swrst_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Pins in, synchronised out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_r <= INIT;
      sync_out <= INIT;
    end else begin
      meta_r <= pin_in;
      sync_out <= meta_r;
    end
  end
endmodule

// *** test/swrst_board.sv ***
// Board strap and SMBus master model facing the reset block.
// Assumes the bench asks for strap values and for the halt-bit clear.
`timescale 1ns/1ns
module swrst_board (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic fundamental_reset_n,
  // Requests from the bench
  input wire logic [3:0] mode_req,
  input wire logic merge_req_n,
  input wire logic halt_req,
  input wire logic clear_req,
  // Device side
  input wire logic halt_bit_set_r,
  output logic [3:0] switch_mode_sel,
  output logic port67_merge_n,
  output logic reset_halt,
  output logic ctl_reset_halt_bit
);
  // Straps move only while the pin reset is low, so they stay static
  always_ff @(posedge clk_sys) begin
    if (!fundamental_reset_n) begin
      switch_mode_sel <= mode_req;
      port67_merge_n <= merge_req_n;
      reset_halt <= halt_req;
    end
  end
  // Halt bit: set by the device, cleared by the SMBus master on request
  always_ff @(posedge clk_sys) begin
    if (reset) ctl_reset_halt_bit <= 1'b0;
    else if (halt_bit_set_r) ctl_reset_halt_bit <= 1'b1;
    else if (clear_req) ctl_reset_halt_bit <= 1'b0;
  end
endmodule

// *** test/swrst_ctrl_tb.sv ***
// Self-checking bench for the reset sequencer and strap decoder.
// Assumes a short procedure count; straps come from the board model.
`timescale 1ns/1ns
module swrst_ctrl_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic fundamental_reset_n = 1'b0;
  logic [3:0] mode_req = 4'h0;
  logic merge_req_n = 1'b1;
  logic halt_req = 1'b0;
  logic clear_req = 1'b0;
  logic [3:0] switch_mode_sel, mode_r, port6_width_r;
  logic port67_merge_n, reset_halt, ctl_reset_halt_bit, core_reset_r;
  logic smbus_enable_r, halted_r, halt_bit_set_r, mode_reserved_r;
  logic eeprom_init_r, single_part_r, port0_disable_r, port2_disable_r;
  logic port67_merged_r, port7_enable_r;
  logic [2:0] upstream_port_r;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [3:0] modes [10] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hA, 4'hB, 4'h3,
    4'hC, 4'hD, 4'hE};
  // Free-running clock at 125 MHz
  always #4 clk_sys = ~clk_sys;
  swrst_board board_u (.clk_sys(clk_sys), .reset(reset),
    .fundamental_reset_n(fundamental_reset_n), .mode_req(mode_req),
    .merge_req_n(merge_req_n), .halt_req(halt_req), .clear_req(clear_req),
    .halt_bit_set_r(halt_bit_set_r), .switch_mode_sel(switch_mode_sel),
    .port67_merge_n(port67_merge_n), .reset_halt(reset_halt),
    .ctl_reset_halt_bit(ctl_reset_halt_bit));
  // Short procedure count keeps each boot to a handful of cycles
  swrst_ctrl #(.PROC_CYCLES(8'h02)) dut_u (.clk_sys(clk_sys), .reset(reset),
    .fundamental_reset_n(fundamental_reset_n), .reset_halt(reset_halt),
    .switch_mode_sel(switch_mode_sel), .port67_merge_n(port67_merge_n),
    .ctl_reset_halt_bit(ctl_reset_halt_bit), .core_reset_r(core_reset_r),
    .smbus_enable_r(smbus_enable_r), .halted_r(halted_r),
    .halt_bit_set_r(halt_bit_set_r), .mode_r(mode_r),
    .mode_reserved_r(mode_reserved_r), .eeprom_init_r(eeprom_init_r),
    .single_part_r(single_part_r), .upstream_port_r(upstream_port_r),
    .port0_disable_r(port0_disable_r), .port2_disable_r(port2_disable_r),
    .port67_merged_r(port67_merged_r), .port6_width_r(port6_width_r),
    .port7_enable_r(port7_enable_r));
  task automatic check(input string what, input logic [3:0] seen,
      input logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Pin reset with straps, release, wait for run or halt (bounded)
  task automatic boot(input logic [3:0] m, input logic mg, input logic h);
    int n;
    @(negedge clk_sys);
    mode_req = m;
    merge_req_n = mg;
    halt_req = h;
    fundamental_reset_n = 1'b0;
    repeat (7) @(negedge clk_sys);
    check("core_reset_in", {3'h0, core_reset_r}, 4'h1);
    check("halted_in", {3'h0, halted_r}, 4'h0);
    check("smbus_in", {3'h0, smbus_enable_r}, 4'h0);
    fundamental_reset_n = 1'b1;
    n = 0;
    while (core_reset_r === 1'b1 && halted_r !== 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    check("boot_len", {3'h0, n >= 3 && n < 30}, 4'h1);
  endtask
  // Decode of one strap setting with the merge strap given
  task automatic mode_case(input logic [3:0] m, input logic mg);
    logic rsv, sp, ee;
    rsv = !(m inside {4'h0, 4'h1, 4'h8, 4'h9, 4'hA, 4'hB});
    sp = !rsv && m[3];
    ee = !rsv && (m == 4'h1 || m == 4'hA || m == 4'hB);
    boot(m, mg, 1'b0);
    check("core_reset", {3'h0, core_reset_r}, 4'h0);
    check("mode", mode_r, m);
    check("reserved", {3'h0, mode_reserved_r}, {3'h0, rsv});
    check("eeprom", {3'h0, eeprom_init_r}, {3'h0, ee});
    check("single", {3'h0, single_part_r}, {3'h0, sp});
    check("upstream", {1'b0, upstream_port_r},
      {2'h0, sp && m[0], 1'b0});
    check("p0_dis", {3'h0, port0_disable_r}, {3'h0, sp && m[0]});
    check("p2_dis", {3'h0, port2_disable_r}, {3'h0, sp && !m[0]});
    check("merged", {3'h0, port67_merged_r}, {3'h0, !mg});
    check("p6_width", port6_width_r, mg ? 4'h4 : 4'h8);
    check("p7_en", {3'h0, port7_enable_r}, {3'h0, mg});
  endtask
  // Halt after the procedure, then release by clearing the bit
  task automatic halt_case();
    int n;
    boot(4'h9, 1'b0, 1'b1);
    check("halt_pulse", {3'h0, halt_bit_set_r}, 4'h1);
    @(negedge clk_sys);
    check("pulse_end", {3'h0, halt_bit_set_r}, 4'h0);
    check("halted", {3'h0, halted_r}, 4'h1);
    check("smbus_en", {3'h0, smbus_enable_r}, 4'h1);
    check("halt_bit", {3'h0, ctl_reset_halt_bit}, 4'h1);
    repeat (12) @(negedge clk_sys);
    check("still_held", {3'h0, core_reset_r}, 4'h1);
    clear_req = 1'b1;
    n = 0;
    while (core_reset_r === 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    clear_req = 1'b0;
    check("released", {3'h0, core_reset_r}, 4'h0);
    check("unhalted", {3'h0, halted_r}, 4'h0);
    check("upstream_h", {1'b0, upstream_port_r}, 4'h2);
  endtask
  // Hang guard: a stuck run counts as a mismatch
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end
  // Main sequence
  initial begin
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    for (int i = 0; i < 10; i++) mode_case(modes[i], i[0]);
    halt_case();
    results();
  end
endmodule
